// ### core/ssq_seq.sv
// output step sequencer: walks a programmed step list and drives setpoints
// assumes requests and phase come from logic on i_mclk, requests as pulses
`timescale 1ns/1ps
`include "ssq_defs.svh"

module ssq_seq #(
  parameter int TICK_CYC = int'(`SSQ_TICK_CYC),
  parameter int STEPS = 1000
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_wr_en,
  input wire logic [`SSQ_STEP_W-1:0] i_wr_addr,
  input wire ssq_pkg::ssq_step_t i_wr_step,
  input wire ssq_pkg::ssq_mode_t i_out_mode,
  input wire logic [3:0] i_refresh_sel,
  input wire logic i_sense_setting,
  input wire logic [`SSQ_PH_W-1:0] i_phase,
  input wire logic i_run,
  input wire logic i_stop,
  input wire logic i_cont,
  input wire logic [1:0] i_branch,
  output logic [`SSQ_STEP_W-1:0] o_step,
  output logic o_running,
  output logic o_holding,
  output logic o_out_en,
  output logic o_sense_en,
  output logic [1:0] o_sync,
  output logic [4:0] o_wave,
  output logic signed [`SSQ_SET_W-1:0] o_acv,
  output logic signed [`SSQ_SET_W-1:0] o_dcv,
  output logic signed [`SSQ_SET_W-1:0] o_freq,
  output logic o_refresh
);
  localparam int TW = $clog2(TICK_CYC + 1);

  // --------------------------------------------------------------------------
  // step memory and sequencing tick
  // --------------------------------------------------------------------------
  ssq_pkg::ssq_step_t mem [0:STEPS-1];
  logic [TW-1:0] pre, next_pre;
  logic tick, next_tick;

  always_ff @(posedge i_mclk) begin
    if (i_wr_en && i_wr_addr <= `SSQ_STEP_MAX) begin
      mem[i_wr_addr] <= i_wr_step;
    end
  end

  always_comb begin
    next_tick = (pre == TW'(TICK_CYC - 1));
    next_pre = next_tick ? '0 : pre + TW'(1);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pre <= '0;
      tick <= 1'b0;
    end else begin
      pre <= next_pre;
      tick <= next_tick;
    end
  end

  // --------------------------------------------------------------------------
  // sequencer state
  // --------------------------------------------------------------------------
  ssq_pkg::ssq_state_t state, next_state;
  ssq_pkg::ssq_step_t stp, next_stp;
  logic [`SSQ_STEP_W-1:0] step, next_step, ret_step, next_ret_step;
  logic [`SSQ_DUR_W-1:0] elapsed, next_elapsed, ret_elapsed, next_ret_elapsed;
  logic loop_act, next_loop_act, br_act, next_br_act;
  logic [`SSQ_STEP_W-1:0] loop_step, next_loop_step;
  logic [`SSQ_CNT_W-1:0] loop_rem, next_loop_rem;
  logic seq_on, next_seq_on, resume, next_resume, ret_hold, next_ret_hold;
  logic ramp_load;
  logic ac_used, on_hit, off_hit;

  ssq_ramp_if rif [3] ();

  assign ac_used = (i_out_mode != ssq_pkg::internal_dc_mode);
  assign on_hit = !ac_used || !stp.on_fixed || i_phase == stp.on_phase;
  assign off_hit = !ac_used || !stp.off_fixed || i_phase == stp.off_phase;

  always_comb begin
    next_state = state;
    next_stp = stp;
    next_step = step;
    next_elapsed = elapsed;
    next_ret_step = ret_step;
    next_ret_elapsed = ret_elapsed;
    next_ret_hold = ret_hold;
    next_loop_act = loop_act;
    next_loop_step = loop_step;
    next_loop_rem = loop_rem;
    next_br_act = br_act;
    next_seq_on = seq_on;
    next_resume = resume;
    ramp_load = 1'b0;
    unique case (state)
      ssq_pkg::st_standby: begin
        if (i_run) begin
          next_seq_on = 1'b1;
          next_step = `SSQ_FIRST_RUN;
          next_elapsed = '0;
          next_state = ssq_pkg::st_load;
        end
      end
      ssq_pkg::st_load: begin
        next_stp = mem[step];
        next_state = ssq_pkg::st_start;
      end
      ssq_pkg::st_start: begin
        ramp_load = 1'b1;
        next_resume = 1'b0;
        if (!seq_on) begin
          next_state = ssq_pkg::st_standby;
        end else if (resume) begin
          next_state = ret_hold ? ssq_pkg::st_hold : ssq_pkg::st_run;
        end else begin
          next_state = ssq_pkg::st_on_wait;
        end
      end
      ssq_pkg::st_on_wait: begin
        if (on_hit) begin
          next_state = ssq_pkg::st_run;
        end
      end
      ssq_pkg::st_run: begin
        // duration counts only here, never while waiting on phase
        if (elapsed >= stp.dur) begin
          next_state = ssq_pkg::st_off_wait;
        end else if (tick) begin
          next_elapsed = elapsed + `SSQ_DUR_W'(1);
        end
      end
      ssq_pkg::st_off_wait: begin
        if (off_hit) begin
          next_elapsed = '0;
          next_state = ssq_pkg::st_load;
          if (stp.jump_en && stp.jump_cnt == '0) begin
            next_step = stp.jump_target_step;
          end else if (stp.jump_en && !(loop_act && loop_step == step)) begin
            next_loop_act = 1'b1;
            next_loop_step = step;
            next_loop_rem = stp.jump_cnt - `SSQ_CNT_W'(1);
            next_step = stp.jump_target_step;
          end else if (stp.jump_en && loop_rem != '0) begin
            next_loop_rem = loop_rem - `SSQ_CNT_W'(1);
            next_step = stp.jump_target_step;
          end else begin
            if (stp.jump_en) begin
              next_loop_act = 1'b0;
            end
            unique case (stp.term)
              ssq_pkg::continue_to_next: begin
                if (step == `SSQ_STEP_MAX) begin
                  next_seq_on = 1'b0;
                  next_step = `SSQ_STANDBY;
                end else begin
                  next_step = step + `SSQ_STEP_W'(1);
                end
              end
              ssq_pkg::hold_step: begin
                next_state = ssq_pkg::st_hold;
                next_elapsed = elapsed;
              end
              default: begin
                if (br_act) begin
                  next_br_act = 1'b0;
                  next_step = ret_step;
                  next_elapsed = ret_elapsed;
                  next_resume = 1'b1;
                end else begin
                  next_seq_on = 1'b0;
                  next_loop_act = 1'b0;
                  next_step = `SSQ_STANDBY;
                end
              end
            endcase
          end
        end
      end
      ssq_pkg::st_hold: begin
        if (i_cont) begin
          next_elapsed = '0;
          next_state = ssq_pkg::st_load;
          if (step == `SSQ_STEP_MAX) begin
            next_seq_on = 1'b0;
            next_step = `SSQ_STANDBY;
          end else begin
            next_step = step + `SSQ_STEP_W'(1);
          end
        end
      end
      default: begin
        next_state = ssq_pkg::st_standby;
      end
    endcase
    // one branch level only; branch 1 wins a tie
    if (seq_on && !br_act && i_branch != 2'h0 && (state == ssq_pkg::st_on_wait
        || state == ssq_pkg::st_run || state == ssq_pkg::st_off_wait
        || state == ssq_pkg::st_hold)) begin
      if ((i_branch[0] && stp.branch_en[0]) || (i_branch[1] && stp.branch_en[1])) begin
        next_br_act = 1'b1;
        next_ret_step = step;
        next_ret_elapsed = elapsed;
        next_ret_hold = (state == ssq_pkg::st_hold);
        next_resume = 1'b0;
        next_elapsed = '0;
        next_state = ssq_pkg::st_load;
        next_step = (i_branch[0] && stp.branch_en[0]) ? stp.branch_selector[0]
                                                      : stp.branch_selector[1];
      end
    end
    if (i_stop && seq_on) begin
      next_seq_on = 1'b0;
      next_br_act = 1'b0;
      next_loop_act = 1'b0;
      next_resume = 1'b0;
      next_elapsed = '0;
      next_step = `SSQ_STANDBY;
      next_state = ssq_pkg::st_load;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state <= ssq_pkg::st_load;
      stp <= '0;
      step <= `SSQ_STANDBY;
      elapsed <= '0;
      ret_step <= `SSQ_STANDBY;
      ret_elapsed <= '0;
      ret_hold <= 1'b0;
      loop_act <= 1'b0;
      loop_step <= `SSQ_STANDBY;
      loop_rem <= '0;
      br_act <= 1'b0;
      seq_on <= 1'b0;
      resume <= 1'b0;
    end else begin
      state <= next_state;
      stp <= next_stp;
      step <= next_step;
      elapsed <= next_elapsed;
      ret_step <= next_ret_step;
      ret_elapsed <= next_ret_elapsed;
      ret_hold <= next_ret_hold;
      loop_act <= next_loop_act;
      loop_step <= next_loop_step;
      loop_rem <= next_loop_rem;
      br_act <= next_br_act;
      seq_on <= next_seq_on;
      resume <= next_resume;
    end
  end

  // --------------------------------------------------------------------------
  // setpoint channels: 0 ac voltage, 1 dc voltage, 2 frequency
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : g_ramp
    assign rif[g].load = ramp_load;
    assign rif[g].mode = (g == 0) ? stp.trans_ac : (g == 1) ? stp.trans_dc
                                                            : stp.trans_freq;
    assign rif[g].target = (g == 0) ? stp.ac_voltage_setpoint
                         : (g == 1) ? stp.dc_voltage_setpoint : stp.freq_setpoint;
    // resumed step sweeps only over what remains of its duration
    assign rif[g].dur = stp.dur - elapsed;
    assign rif[g].run = tick && (state == ssq_pkg::st_run || state == ssq_pkg::st_standby);
    ssq_ramp u_ramp (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .r(rif[g])
    );
  end

  // --------------------------------------------------------------------------
  // reading refresh timer
  // --------------------------------------------------------------------------
  logic [`SSQ_RFR_W-1:0] rfr, next_rfr, rfr_lim;
  logic next_refresh;

  always_comb begin
    unique case (i_refresh_sel)
      4'h1: rfr_lim = `SSQ_RFR_W'(`SSQ_MS2TICK(`SSQ_RFR_0P1_MS));
      4'h2: rfr_lim = `SSQ_RFR_W'(`SSQ_MS2TICK(`SSQ_RFR_0P25_MS));
      4'h3: rfr_lim = `SSQ_RFR_W'(`SSQ_MS2TICK(`SSQ_RFR_0P5_MS));
      4'h4: rfr_lim = `SSQ_RFR_W'(`SSQ_MS2TICK(`SSQ_RFR_1_MS));
      4'h5: rfr_lim = `SSQ_RFR_W'(`SSQ_MS2TICK(`SSQ_RFR_2_MS));
      4'h6: rfr_lim = `SSQ_RFR_W'(`SSQ_MS2TICK(`SSQ_RFR_5_MS));
      4'h7: rfr_lim = `SSQ_RFR_W'(`SSQ_MS2TICK(`SSQ_RFR_10_MS));
      4'h8: rfr_lim = `SSQ_RFR_W'(`SSQ_MS2TICK(`SSQ_RFR_20_MS));
      default: rfr_lim = `SSQ_RFR_W'(`SSQ_MS2TICK(`SSQ_RFR_FAST_MS));
    endcase
    next_refresh = tick && (rfr >= rfr_lim - `SSQ_RFR_W'(1));
    next_rfr = next_refresh ? '0 : (tick ? rfr + `SSQ_RFR_W'(1) : rfr);
  end

  // --------------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rfr <= '0;
      o_refresh <= 1'b0;
      o_step <= `SSQ_STANDBY;
      o_running <= 1'b0;
      o_holding <= 1'b0;
      o_out_en <= 1'b0;
      o_sense_en <= 1'b0;
      o_sync <= 2'h0;
      o_wave <= 5'h00;
      o_acv <= '0;
      o_dcv <= '0;
      o_freq <= '0;
    end else begin
      rfr <= next_rfr;
      o_refresh <= next_refresh;
      o_step <= step;
      o_running <= seq_on;
      o_holding <= (state == ssq_pkg::st_hold);
      o_out_en <= (state == ssq_pkg::st_run) || (state == ssq_pkg::st_off_wait && !off_hit)
                  || state == ssq_pkg::st_hold || state == ssq_pkg::st_standby;
      o_sense_en <= i_sense_setting && !seq_on;
      o_sync <= stp.sync_code;
      o_wave <= stp.wave;
      o_acv <= ac_used ? rif[0].value : '0;
      o_dcv <= (i_out_mode != ssq_pkg::internal_ac_mode) ? rif[1].value : '0;
      o_freq <= ac_used ? rif[2].value : '0;
    end
  end
endmodule : ssq_seq

// ### core/ssq_defs.svh
// constants for the output step sequencer: timing, limits, step numbers
// assumes a single 50 MHz system clock and a 100 us sequencing tick
`ifndef SSQ_DEFS_SVH
`define SSQ_DEFS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SSQ_CLK_HZ 64'd50000000
`define SSQ_TICK_US 64'd100
`define SSQ_TICK_CYC ((`SSQ_TICK_US * `SSQ_CLK_HZ) / 64'd1000000)
`define SSQ_MS2TICK(ms) (((ms) * 64'd1000) / `SSQ_TICK_US)

// reading refresh intervals in ms
`define SSQ_RFR_FAST_MS 64'd5
`define SSQ_RFR_0P1_MS 64'd100
`define SSQ_RFR_0P25_MS 64'd250
`define SSQ_RFR_0P5_MS 64'd500
`define SSQ_RFR_1_MS 64'd1000
`define SSQ_RFR_2_MS 64'd2000
`define SSQ_RFR_5_MS 64'd5000
`define SSQ_RFR_10_MS 64'd10000
`define SSQ_RFR_20_MS 64'd20000

// ----------------------------------------------------------------------------
// step numbers and field widths
// ----------------------------------------------------------------------------
`define SSQ_STEP_W 10
`define SSQ_STEP_MAX 10'h3e7
`define SSQ_STANDBY 10'h000
`define SSQ_FIRST_RUN 10'h001
`define SSQ_DUR_W 27
`define SSQ_SET_W 16
`define SSQ_CNT_W 14
`define SSQ_PH_W 12
`define SSQ_RFR_W 18

`endif

// ### core/ssq_pkg.sv
// types shared by the step sequencer and its setpoint ramp units
// assumes ssq_defs.svh is on the include path
`include "ssq_defs.svh"

package ssq_pkg;

  // --------------------------------------------------------------------------
  // enumerations
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    constant_setpoint = 2'h0,
    keep_previous = 2'h1,
    linear_sweep = 2'h2
  } ssq_trans_t;

  typedef enum logic [1:0] {
    continue_to_next = 2'h0,
    hold_step = 2'h1,
    end_sequence = 2'h2
  } ssq_term_t;

  typedef enum logic [1:0] {
    internal_dc_mode = 2'h0,
    internal_ac_mode = 2'h1,
    internal_combined_mode = 2'h2
  } ssq_mode_t;

  typedef enum logic [2:0] {
    st_standby = 3'h0,
    st_load = 3'h1,
    st_start = 3'h2,
    st_on_wait = 3'h3,
    st_run = 3'h4,
    st_off_wait = 3'h5,
    st_hold = 3'h6
  } ssq_state_t;

  // --------------------------------------------------------------------------
  // one programmed step; wave 0 sine, 1 square, 2 triangle, 3..18 arbitrary
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`SSQ_DUR_W-1:0] dur;
    logic [`SSQ_SET_W-1:0] ac_voltage_setpoint;
    logic [`SSQ_SET_W-1:0] dc_voltage_setpoint;
    logic [`SSQ_SET_W-1:0] freq_setpoint;
    ssq_trans_t trans_ac;
    ssq_trans_t trans_dc;
    ssq_trans_t trans_freq;
    logic [4:0] wave;
    logic jump_en;
    logic [`SSQ_STEP_W-1:0] jump_target_step;
    logic [`SSQ_CNT_W-1:0] jump_cnt;
    logic [1:0] branch_en;
    logic [1:0][`SSQ_STEP_W-1:0] branch_selector;
    ssq_term_t term;
    logic [1:0] sync_code;
    logic on_fixed;
    logic [`SSQ_PH_W-1:0] on_phase;
    logic off_fixed;
    logic [`SSQ_PH_W-1:0] off_phase;
  } ssq_step_t;

endpackage : ssq_pkg

// ### core/ssq_ramp_if.sv
// link between the sequencer and one setpoint ramp unit
// assumes both ends share the system clock
`timescale 1ns/1ps
`include "ssq_defs.svh"

interface ssq_ramp_if;
  logic load;
  ssq_pkg::ssq_trans_t mode;
  logic signed [`SSQ_SET_W-1:0] target;
  logic [`SSQ_DUR_W-1:0] dur;
  logic run;
  logic signed [`SSQ_SET_W-1:0] value;

  modport ctl (output load, output mode, output target, output dur, output run,
    input value);
  modport ramp (input load, input mode, input target, input dur, input run,
    output value);
endinterface : ssq_ramp_if

// ### core/ssq_ramp.sv
// one setpoint channel: constant, keep or linear sweep toward a target
// assumes load is a one-cycle pulse and run pulses once per sequencing tick
`timescale 1ns/1ps
`include "ssq_defs.svh"

module ssq_ramp (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  ssq_ramp_if.ramp r
);
  logic signed [`SSQ_SET_W-1:0] val, next_val, tgt, next_tgt;
  logic [`SSQ_DUR_W:0] acc, next_acc;
  logic [`SSQ_DUR_W-1:0] dur, next_dur;
  logic [`SSQ_SET_W:0] diff, next_diff;

  // --------------------------------------------------------------------------
  // dda sweep: per tick add |delta|, one lsb step each time duration is passed
  // limitation: one tick's worth of lsb steps per tick or more (one per clock) makes it lag
  // --------------------------------------------------------------------------
  always_comb begin
    next_val = val;
    next_tgt = tgt;
    next_acc = acc;
    next_dur = dur;
    next_diff = diff;
    if (r.load) begin
      next_acc = '0;
      next_dur = r.dur;
      if (r.mode == ssq_pkg::keep_previous) begin
        next_tgt = val;
      end else if (r.mode == ssq_pkg::linear_sweep && r.dur != '0) begin
        next_tgt = r.target;
        // widen before subtracting so a full-scale swing cannot wrap
        next_diff = (r.target > val) ? (`SSQ_SET_W+1)'(r.target) - (`SSQ_SET_W+1)'(val)
                                     : (`SSQ_SET_W+1)'(val) - (`SSQ_SET_W+1)'(r.target);
      end else begin
        next_tgt = r.target;
        next_val = r.target;
      end
    end else if (acc >= {1'b0, dur} && val != tgt) begin
      next_acc = acc - {1'b0, dur};
      next_val = (val < tgt) ? val + 16'sh0001 : val - 16'sh0001;
    end else if (r.run) begin
      next_acc = acc + (`SSQ_DUR_W+1)'(diff);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      val <= '0;
      tgt <= '0;
      acc <= '0;
      dur <= '0;
      diff <= '0;
    end else begin
      val <= next_val;
      tgt <= next_tgt;
      acc <= next_acc;
      dur <= next_dur;
      diff <= next_diff;
    end
  end

  assign r.value = val;
endmodule : ssq_ramp

// ### verification/ssq_seq_properties.sv
// concurrent checks on the step sequencer's top ports
// assumes one clock domain and a sync active-low reset
`timescale 1ns/1ps
`include "ssq_defs.svh"

module ssq_seq_properties (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire ssq_pkg::ssq_mode_t i_out_mode,
  input wire logic i_run,
  input wire logic i_stop,
  input wire logic i_cont,
  input wire logic [1:0] i_branch,
  input wire logic [`SSQ_STEP_W-1:0] o_step,
  input wire logic o_running,
  input wire logic o_holding,
  input wire logic o_sense_en,
  input wire logic signed [`SSQ_SET_W-1:0] o_acv,
  input wire logic signed [`SSQ_SET_W-1:0] o_dcv,
  input wire logic signed [`SSQ_SET_W-1:0] o_freq,
  input wire logic o_refresh
);
  // ----
  // checks
  // ----
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  logic quiet;
  // past depth covers a one-cycle output lag behind the state
  assign quiet = !(i_cont || i_stop || (|i_branch));

  reset_clears_a: assert property (disable iff (1'h0)
    !i_rst_b |=> o_step == 10'h000 && !o_running)
    else $error("reset left step or run state");
  step_range_a: assert property (o_step <= 10'h3e7)
    else $error("step number past last step");
  sense_off_a: assert property (o_running [*3] |-> !o_sense_en)
    else $error("sense on while running");
  hold_stays_a: assert property (
    o_holding && quiet && $past(quiet) && $past(quiet, 2) |=> o_holding)
    else $error("hold left without continue");
  hold_running_a: assert property (o_holding |-> o_running)
    else $error("hold outside a run");
  refresh_pulse_a: assert property (o_refresh |=> !o_refresh)
    else $error("refresh pulse too long");
  run_start_a: assert property (
    !o_running [*6] ##0 (i_run && !i_stop) |-> ##2 (o_running && o_step == 10'h001))
    else $error("run did not start step one");
  end_standby_a: assert property ($fell(o_running) |-> ##[0:2] o_step == 10'h000)
    else $error("sequence end not at standby");
  dc_zero_a: assert property (
    i_out_mode == ssq_pkg::internal_dc_mode && $past(i_out_mode) == ssq_pkg::internal_dc_mode
    |-> o_acv == 16'h0000 && o_freq == 16'h0000)
    else $error("ac setpoints live in dc mode");
  ac_nodc_a: assert property (
    i_out_mode == ssq_pkg::internal_ac_mode && $past(i_out_mode) == ssq_pkg::internal_ac_mode
    |-> o_dcv == 16'h0000)
    else $error("dc setpoint live in ac mode");
  cover property (o_holding);
  cover property (o_refresh);
  cover property ($fell(o_running));
endmodule : ssq_seq_properties

// ### verification/ssq_keys.sv
// operator key and remote request model
// assumes press is called by the bench between falling edges
`timescale 1ns/1ps

module ssq_keys (
  input wire logic i_mclk,
  output logic o_run,
  output logic o_stop,
  output logic o_cont,
  output logic [1:0] o_branch
);
  initial {o_stop, o_branch, o_cont, o_run} = 5'h00;
  // ----
  // one key: {stop, branch2, branch1, continue, run}
  // ----
  task automatic press(input logic [4:0] k);
    @(negedge i_mclk);
    {o_stop, o_branch, o_cont, o_run} = k;
    @(negedge i_mclk);
    {o_stop, o_branch, o_cont, o_run} = 5'h00;
  endtask : press
endmodule : ssq_keys

// ### verification/tb.sv
// self-checking bench for the step sequencer
// assumes a short sequencing tick of 10 clocks
`timescale 1ns/1ps
`include "ssq_defs.svh"

module tb;
  logic i_mclk, i_rst_b, i_wr_en, i_sense_setting, i_run, i_stop, i_cont;
  logic o_running, o_holding, o_out_en, o_sense_en, o_refresh;
  logic [9:0] i_wr_addr, o_step;
  logic [3:0] i_refresh_sel;
  logic [1:0] i_branch, o_sync;
  logic [4:0] o_wave;
  logic signed [15:0] o_acv, o_dcv, o_freq;
  ssq_pkg::ssq_step_t i_wr_step, s;
  ssq_pkg::ssq_mode_t i_out_mode;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  time t1;
  logic [11:0] i_phase = 12'h000;
  logic [1:0] sy_r [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [4:0] wv_r [4] = '{5'h00, 5'h01, 5'h02, 5'h12};
  logic [15:0] ac_r [4] = '{16'h0040, 16'h0100, 16'h0200, 16'h0300};
  logic [3:0] rf_sel [3] = '{4'h0, 4'h1, 4'hf};
  int rf_cyc [3] = '{500, 10000, 500};

  ssq_seq #(.TICK_CYC(10)) uut (.i_mclk, .i_rst_b, .i_wr_en, .i_wr_addr, .i_wr_step,
    .i_out_mode, .i_refresh_sel, .i_sense_setting, .i_phase, .i_run, .i_stop,
    .i_cont, .i_branch, .o_step, .o_running, .o_holding, .o_out_en, .o_sense_en, .o_sync,
    .o_wave, .o_acv, .o_dcv, .o_freq, .o_refresh);
  ssq_keys keys (.i_mclk, .o_run(i_run), .o_stop(i_stop), .o_cont(i_cont),
    .o_branch(i_branch));

  // ----
  // helpers
  // ----
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wait_step(input logic [9:0] st);
    n = 0;
    while (o_step !== st && n < 30000) begin
      @(negedge i_mclk);
      n++;
    end
    cmp(n < 30000, 1);
    if (n >= 30000) give_verdict();
  endtask : wait_step

  task automatic wait_out(input logic lvl);
    n = 0;
    while (o_out_en !== lvl && n < 30000) begin
      @(negedge i_mclk);
      n++;
    end
    cmp(n < 30000, 1);
    if (n >= 30000) give_verdict();
  endtask : wait_out

  task automatic pulse_wait();
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (o_refresh !== 1'h1 && n < 30000);
    if (n >= 30000) begin
      miscompares++;
      give_verdict();
    end
  endtask : pulse_wait

  task automatic wr(input logic [9:0] a, input ssq_pkg::ssq_step_t st);
    @(negedge i_mclk);
    i_wr_en = 1'h1;
    i_wr_addr = a;
    i_wr_step = st;
    @(negedge i_mclk);
    i_wr_en = 1'h0;
  endtask : wr

  function automatic ssq_pkg::ssq_step_t mk(input logic [1:0] sy, input logic [4:0] wv,
    input logic [15:0] ac, input ssq_pkg::ssq_term_t tm);
    ssq_pkg::ssq_step_t r;
    r = '0;
    r.dur = 27'h4;
    r.ac_voltage_setpoint = ac;
    r.dc_voltage_setpoint = ac;
    r.freq_setpoint = 16'h0032;
    r.sync_code = sy;
    r.wave = wv;
    r.term = tm;
    return r;
  endfunction : mk

  initial begin
    i_mclk = 1'h0;
    forever #10 i_mclk = ~i_mclk;
  end

  // free-running phase, one tenth of a degree per clock
  always @(negedge i_mclk) i_phase <= (i_phase == 12'he0f) ? 12'h000 : i_phase + 12'h001;

  // ----
  // main sequence
  // ----
  initial begin
    {i_rst_b, i_wr_en, i_wr_addr, i_wr_step, i_refresh_sel} = '0;
    i_out_mode = ssq_pkg::internal_combined_mode;
    i_sense_setting = 1'h1;
    repeat (12) @(negedge i_mclk);
    i_rst_b = 1'h1;
    // step 3 ends the list, so at least two steps run
    for (int i = 0; i < 4; i++) begin
      wr(i[9:0], mk(sy_r[i], wv_r[i], ac_r[i], i == 3 ? ssq_pkg::end_sequence
        : ssq_pkg::continue_to_next));
    end
    i_rst_b = 1'h0;
    repeat (2) @(negedge i_mclk);
    i_rst_b = 1'h1;
    cmp(o_step, 10'h000);
    repeat (8) @(negedge i_mclk);
    cmp(o_sense_en, 1);
    keys.press(5'h01);
    for (int i = 1; i < 4; i++) begin
      wait_step(i[9:0]);
      if (i == 1) t1 = $time;
      if (i == 2) cmp(($time - t1) / 20 inside {[30:55]}, 1);
      repeat (6) @(negedge i_mclk);
      cmp(o_sync, sy_r[i]);
      cmp(o_wave, wv_r[i]);
      cmp(o_acv, ac_r[i]);
      cmp(o_dcv, ac_r[i]);
      cmp(o_freq, 16'h0032);
    end
    wait_step(10'h000);
    repeat (6) @(negedge i_mclk);
    cmp(o_running, 0);
    cmp(o_sense_en, 1);
    i_out_mode = ssq_pkg::internal_dc_mode;
    repeat (4) @(negedge i_mclk);
    cmp(o_acv, 16'h0000);
    cmp(o_freq, 16'h0000);
    i_out_mode = ssq_pkg::internal_ac_mode;
    repeat (4) @(negedge i_mclk);
    cmp(o_dcv, 16'h0000);
    i_out_mode = ssq_pkg::internal_combined_mode;
    // jump loop, hold and one branch in a single run
    s = mk(2'h2, 5'h02, 16'h0200, ssq_pkg::continue_to_next);
    s.jump_en = 1'h1;
    s.jump_target_step = 10'h001;
    s.jump_cnt = 14'h0002;
    wr(10'h002, s);
    s = mk(2'h3, 5'h12, 16'h0300, ssq_pkg::hold_step);
    s.branch_en = 2'h1;
    s.branch_selector[0] = 10'h005;
    wr(10'h003, s);
    wr(10'h004, mk(2'h1, 5'h00, 16'h0100, ssq_pkg::end_sequence));
    wr(10'h005, mk(2'h2, 5'h01, 16'h0200, ssq_pkg::end_sequence));
    keys.press(5'h02);
    repeat (4) @(negedge i_mclk);
    cmp(o_running, 0);
    keys.press(5'h01);
    for (int k = 0; k < 3; k++) begin
      wait_step(10'h001);
      wait_step(10'h002);
    end
    wait_step(10'h003);
    cmp(n < 60, 1);
    repeat (80) @(negedge i_mclk);
    cmp(o_holding, 1);
    keys.press(5'h08);
    repeat (4) @(negedge i_mclk);
    cmp(o_step, 10'h003);
    cmp(o_holding, 1);
    keys.press(5'h04);
    wait_step(10'h005);
    wait_step(10'h003);
    repeat (8) @(negedge i_mclk);
    cmp(o_holding, 1);
    keys.press(5'h02);
    wait_step(10'h004);
    wait_step(10'h000);
    // zero count: the loop must outlast the earlier finite count of two
    s = mk(2'h2, 5'h02, 16'h0200, ssq_pkg::continue_to_next);
    s.jump_en = 1'h1;
    s.jump_target_step = 10'h001;
    wr(10'h002, s);
    keys.press(5'h01);
    for (int k = 0; k < 3; k++) begin
      wait_step(10'h002);
      wait_step(10'h001);
    end
    keys.press(5'h10);
    wait_step(10'h000);
    // fixed phases, keep on ac and a short sweep on dc, from standby values
    s = mk(2'h1, 5'h00, 16'h0300, ssq_pkg::end_sequence);
    s.dc_voltage_setpoint = 16'h0048;
    s.trans_ac = ssq_pkg::keep_previous;
    s.trans_dc = ssq_pkg::linear_sweep;
    s.on_fixed = 1'h1;
    s.on_phase = 12'h100;
    s.off_fixed = 1'h1;
    s.off_phase = 12'h200;
    wr(10'h001, s);
    keys.press(5'h01);
    wait_step(10'h001);
    wait_out(1'h1);
    cmp(i_phase, 12'h101);
    cmp(o_dcv, 16'h0040);
    wait_out(1'h0);
    cmp(i_phase, 12'h200);
    cmp(o_dcv, 16'h0048);
    cmp(o_acv, 16'h0040);
    wait_step(10'h000);
    i_sense_setting = 1'h0;
    repeat (3) @(negedge i_mclk);
    cmp(o_sense_en, 0);
    for (int i = 0; i < 3; i++) begin
      i_refresh_sel = rf_sel[i];
      pulse_wait();
      pulse_wait();
      cmp(n, rf_cyc[i]);
    end
    give_verdict();
  end
endmodule : tb

bind ssq_seq ssq_seq_properties props (.i_mclk, .i_rst_b, .i_out_mode, .i_run, .i_stop,
  .i_cont, .i_branch, .o_step, .o_running, .o_holding, .o_sense_en, .o_acv, .o_dcv,
  .o_freq, .o_refresh);
